/* src/lhb_regs.vh */
`ifndef LHB_REGS_VH
`define LHB_REGS_VH
// system clock period in ps (250 MHz)
`define LHB_TS_PS 4000
// longest acknowledge hold: 4 periods plus 2 ns
`define LHB_ACK_MAX_NS 2
`define LHB_ACK_MAX_CYC 4
// read data ready after ack: 1 period plus 5 ns (one cycle used)
`define LHB_ACK_DATA_CYC 1
// read data after strobe without ack: 4 periods plus 18 ns
`define LHB_NOACK_DATA_CYC 4
// bus modes
`define LHB_MODE_ACK 2'h0
`define LHB_MODE_NOACK 2'h1
`define LHB_MODE_ESTB 2'h2
// clock divider select codes
`define LHB_DIV4 2'h0
`define LHB_DIV8 2'h1
`define LHB_DIV16 2'h2
// colour depth codes
`define LHB_BPP1 2'h0
`define LHB_BPP2 2'h1
`define LHB_BPP4 2'h2
`endif

/* src/lhb_sync.v */
`timescale 1ns/1ps
// three-stage pin synchroniser with agreement filter
module lhb_sync
(
    input wire ref_clk_i, // system clock
    input wire nrst_i, // async reset, active low
    input wire [3:0] pin_i, // raw pins
    output reg [3:0] pin_o // filtered level
);
    reg [3:0] s1;
    reg [3:0] s2;
    reg [3:0] s3;
    // second and third stages must agree before the level moves
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1 <= 4'hf;
            s2 <= 4'hf;
            s3 <= 4'hf;
            pin_o <= 4'hf;
        end
        else
        begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            pin_o <= (s2 & s3) | (pin_o & (s2 | s3));
        end
    end
endmodule // lhb_sync

/* src/lhb_port.v */
`timescale 1ns/1ps
`include "lhb_regs.vh"
module lhb_port
(
    input wire ref_clk_i, // system clock
    input wire nrst_i, // async reset, active low
    input wire [1:0] bus_mode_i, // bus style
    input wire direct_i, // direct interface selected
    input wire power_save_i, // power save mode
    input wire cs_n_i, // chip select pin
    input wire addr_strobe_n_i, // address strobe pin
    input wire rd_n_i, // data strobe pin, or enable on the enable bus
    input wire wr_n_i, // direction pin, high for a read
    input wire [7:0] data_i, // host write data
    output reg [7:0] data_o, // read data to host
    output wire data_oe_o, // read data drive enable
    output reg transfer_ack_n_o, // acknowledge level
    output reg transfer_ack_oe_o, // acknowledge drive enable
    output reg wr_stb_o, // captured write pulse
    output reg [7:0] wr_data_o, // captured write data
    output reg rd_stb_o, // read fetch pulse
    input wire [7:0] rd_data_i, // memory read data
    input wire [1:0] clock_div_select_i, // divider select pins
    input wire [1:0] bpp_i, // colour depth
    input wire [7:0] total_row_bytes_i, // total bytes per row
    input wire [7:0] row_bytes_i, // bytes per row
    output reg shift_clk_en_o, // divided clock tick
    output reg line_pulse_o, // line pulse
    output reg window_o // memory access window open
);
    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    wire [3:0] pins;
    wire cs_n;
    wire as_n;
    wire rd_n;
    wire wr_n;
    lhb_sync u_sync
    (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .pin_i({cs_n_i, addr_strobe_n_i, rd_n_i, wr_n_i}),
        .pin_o(pins)
    );
    assign cs_n = pins[3];
    assign as_n = pins[2];
    assign rd_n = pins[1];
    assign wr_n = pins[0];

    // write data passes the same filter so it lines up with the strobes
    wire [7:0] data_s;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_dsync
            lhb_sync u_dsync
            (
                .ref_clk_i(ref_clk_i),
                .nrst_i(nrst_i),
                .pin_i(data_i[4*g+3:4*g]),
                .pin_o(data_s[4*g+3:4*g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------
    reg active_q;
    reg is_read_q;
    reg [2:0] cnt;
    reg ack_done;
    reg rd_oe;
    wire estb;
    wire active;
    wire is_read;
    assign estb = (bus_mode_i == `LHB_MODE_ESTB);
    // enable bus: rd_n carries the enable high; elsewhere rd_n is the data strobe
    // wr_n is the direction level on every bus style, high for a read
    assign active = !cs_n && (estb ? rd_n : !rd_n && (bus_mode_i != `LHB_MODE_ACK || !as_n));
    assign is_read = wr_n;
    assign data_oe_o = rd_oe;

    // cycle sequencing, ack generation and data capture
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            active_q <= 1'b0;
            is_read_q <= 1'b0;
            cnt <= 3'h0;
            ack_done <= 1'b0;
            rd_oe <= 1'b0;
            data_o <= 8'h00;
            transfer_ack_n_o <= 1'b1;
            transfer_ack_oe_o <= 1'b0;
            wr_stb_o <= 1'b0;
            wr_data_o <= 8'h00;
            rd_stb_o <= 1'b0;
        end
        else
        begin
            active_q <= active;
            wr_stb_o <= 1'b0;
            rd_stb_o <= 1'b0;
            if (active && !active_q)
            begin
                is_read_q <= is_read;
                cnt <= 3'h0;
                ack_done <= 1'b0;
                rd_stb_o <= is_read;
                if (bus_mode_i == `LHB_MODE_ACK)
                begin
                    transfer_ack_oe_o <= 1'b1;
                    transfer_ack_n_o <= 1'b1;
                end
            end
            else if (active)
            begin
                if (cnt != 3'h7)
                    cnt <= cnt + 3'h1;
                // data fetched at cycle 1, ack at 2 so data leads ack
                if (cnt == 3'h1 && is_read_q)
                    data_o <= rd_data_i;
                if (bus_mode_i == `LHB_MODE_ACK && cnt == 3'h2 && !ack_done)
                begin
                    transfer_ack_n_o <= 1'b0;
                    ack_done <= 1'b1;
                end
                if (!transfer_ack_n_o && cnt == 3'h2 + `LHB_ACK_MAX_CYC - 3'h1)
                    transfer_ack_n_o <= 1'b1;
                if (is_read_q)
                    rd_oe <= 1'b1;
                if (!is_read_q)
                    wr_data_o <= data_s;
            end
            if (!active && active_q)
            begin
                // strobe ended
                if (!is_read_q)
                    wr_stb_o <= 1'b1;
                transfer_ack_n_o <= 1'b1;
                if (direct_i && power_save_i)
                    transfer_ack_oe_o <= 1'b0;
                rd_oe <= 1'b0;
            end
            else if (!active && bus_mode_i == `LHB_MODE_ACK && as_n && !(direct_i && power_save_i))
            begin
                transfer_ack_n_o <= 1'b1;
                transfer_ack_oe_o <= 1'b0;
            end
            if (estb && cs_n)
                rd_oe <= 1'b0;
            if (bus_mode_i != `LHB_MODE_ACK)
                transfer_ack_oe_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // clock divider and text mode access window
    // ------------------------------------------------------------
    reg [3:0] div_cnt;
    reg [8:0] byte_cnt;
    reg [13:0] win_cnt;
    wire [3:0] div_last;
    wire [8:0] row_end;
    wire [2:0] k;
    wire [8:0] win_bytes;
    assign div_last = (clock_div_select_i == `LHB_DIV4) ? 4'h3 :
                      (clock_div_select_i == `LHB_DIV8) ? 4'h7 : 4'hf;
    assign row_end = {1'b0, total_row_bytes_i};
    assign k = (bpp_i == `LHB_BPP1) ? 3'h3 : (bpp_i == `LHB_BPP2) ? 3'h2 : 3'h1;
    assign win_bytes = {1'b0, total_row_bytes_i} - {1'b0, row_bytes_i} - {6'h00, k};

    // one divided tick per div_last+1 cycles, row counted in bytes
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            div_cnt <= 4'h0;
            byte_cnt <= 9'h000;
            win_cnt <= 14'h0000;
            shift_clk_en_o <= 1'b0;
            line_pulse_o <= 1'b0;
            window_o <= 1'b0;
        end
        else
        begin
            shift_clk_en_o <= (div_cnt == div_last);
            div_cnt <= (div_cnt >= div_last) ? 4'h0 : div_cnt + 4'h1;
            if (window_o)
            begin
                if (win_cnt <= 14'h0001)
                    window_o <= 1'b0;
                win_cnt <= win_cnt - 14'h0001;
            end
            if (div_cnt == div_last)
            begin
                if (byte_cnt >= row_end)
                begin
                    byte_cnt <= 9'h000;
                    line_pulse_o <= 1'b1;
                end
                else
                    byte_cnt <= byte_cnt + 9'h001;
                if (line_pulse_o)
                begin
                    // line pulse falls: window opens for win_bytes x div x 2 cycles
                    line_pulse_o <= 1'b0;
                    window_o <= !win_bytes[8] && win_bytes != 9'h000;
                    win_cnt <= {win_bytes[7:0], 1'b0} * ({10'h000, div_last} + 14'h0001);
                end
            end
        end
    end
endmodule // lhb_port

/* test/lhb_port_checker.sv */
`timescale 1ns/1ps
module lhb_chk
(
    input wire ref_clk_i, // clk
    input wire nrst_i, // rst
    input wire [1:0] bus_mode_i, // mode
    input wire direct_i, // direct
    input wire power_save_i, // save
    input wire cs_n_i, // cs
    input wire addr_strobe_n_i, // as
    input wire rd_n_i, // strobe
    input wire wr_n_i, // dir
    input wire [7:0] data_o, // rdata
    input wire data_oe_o, // oe
    input wire transfer_ack_n_o, // ack
    input wire transfer_ack_oe_o, // ack oe
    input wire wr_stb_o, // write pulse
    input wire [7:0] wr_data_o, // captured write data
    input wire [7:0] data_i, // host write data
    input wire rd_stb_o, // fetch
    input wire [7:0] rd_data_i, // mem
    input wire [1:0] clock_div_select_i, // div
    input wire [1:0] bpp_i, // bpp
    input wire [7:0] total_row_bytes_i, // total
    input wire [7:0] row_bytes_i, // row
    input wire shift_clk_en_o, // divided tick
    input wire line_pulse_o, // line pulse
    input wire window_o // window
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (!nrst_i);
reg [15:0] wcnt;
integer wexp;
// expected window length from the configuration pins
always @*
    wexp = (total_row_bytes_i - row_bytes_i - (bpp_i == 2'h0 ? 3 : bpp_i == 2'h1 ? 2 : 1)) *
        (clock_div_select_i == 2'h0 ? 4 : clock_div_select_i == 2'h1 ? 8 : 16) * 2;
// cycles the window has been open
always @(posedge ref_clk_i or negedge nrst_i)
    if (!nrst_i)
        wcnt <= 16'h0;
    else
        wcnt <= window_o ? wcnt + 16'h1 : 16'h0;
a_ack_hold_max: assert property ($fell(transfer_ack_n_o) |-> ##[1:4] transfer_ack_n_o)
    else $error("ack held too long");
a_ack_data_ok: assert property ($fell(transfer_ack_n_o) && $past(rd_stb_o, 3)
    |-> data_oe_o && data_o == $past(rd_data_i, 2))
    else $error("no data at ack");
a_fetch_data: assert property (rd_stb_o |-> ##2 data_o == $past(rd_data_i) && data_oe_o)
    else $error("read data wrong");
a_noack_latency: assert property (bus_mode_i == 2'h1 && wr_n_i && !cs_n_i && $fell(rd_n_i) |-> ##[1:8] data_oe_o)
    else $error("read data late");
a_ack_float: assert property (direct_i && power_save_i && bus_mode_i == 2'h0 && $rose(rd_n_i)
    |-> ##[1:6] !transfer_ack_oe_o)
    else $error("ack not floated");
a_ack_release: assert property (!(direct_i && power_save_i) && bus_mode_i == 2'h0 && $rose(addr_strobe_n_i)
    |-> ##[1:6] transfer_ack_n_o)
    else $error("ack not released");
a_sync_delay: assert property ($fell(rd_n_i) |-> !rd_stb_o [*2])
    else $error("strobe used unsynced");
a_window_len: assert property ($fell(window_o) |-> wcnt == wexp)
    else $error("window length wrong");
a_window_start: assert property ($rose(window_o) |-> $fell(line_pulse_o))
    else $error("window not at line fall");
a_window_opens: assert property ($fell(line_pulse_o) && wexp > 0 |-> window_o)
    else $error("window did not open");
a_div_gap: assert property (shift_clk_en_o |=> !shift_clk_en_o [*3])
    else $error("divided tick too soon");
a_div_four: assert property (shift_clk_en_o && clock_div_select_i == 2'h0 |-> ##4 shift_clk_en_o)
    else $error("divide by four wrong");
a_div_eight: assert property (shift_clk_en_o && clock_div_select_i == 2'h1 |-> ##8 shift_clk_en_o)
    else $error("divide by eight wrong");
a_div_sixteen: assert property (shift_clk_en_o && clock_div_select_i == 2'h2 |-> ##16 shift_clk_en_o)
    else $error("divide by sixteen wrong");
a_write_capture: assert property (wr_stb_o |-> wr_data_o == $past(data_i, 6))
    else $error("write data not captured");
endmodule // lhb_chk
bind lhb_port lhb_chk lhb_chk_inst (.*);

/* test/lhb_host.sv */
`timescale 1ns/1ps
module lhb_host
(
    input wire ref_clk_i, // clk
    input wire ack_n_i, // ack
    input wire [7:0] rdata_i, // rdata
    output reg cs_n_o, // cs
    output reg as_n_o, // as
    output reg stb_o, // strobe
    output reg dir_o, // high reads
    output reg [7:0] wd_o // wdata
);
reg [7:0] got;
reg tmo;
integer i;
initial {cs_n_o, as_n_o, stb_o, dir_o, wd_o, tmo} = {4'hf, 8'h5a, 1'b0};
// one byte transfer; strobe idles high except on the enable bus
task xfer(input rd, input [7:0] wd, input [1:0] mode);
    begin
        stb_o = mode != 2'h2;
        wd_o = rd ? ~wd_o : wd;
        dir_o = rd;
        @(negedge ref_clk_i);
        {cs_n_o, as_n_o} = 2'h0;
        repeat (3) @(negedge ref_clk_i);
        stb_o = ~stb_o;
        for (i = 0; i < (mode == 2'h0 ? 20 : 9) && (mode != 2'h0 || ack_n_i); i = i + 1)
            @(negedge ref_clk_i);
        tmo = tmo | (mode == 2'h0 && i == 20);
        @(negedge ref_clk_i);
        got = rdata_i;
        stb_o = ~stb_o;
        @(negedge ref_clk_i);
        {cs_n_o, as_n_o} = 2'h3;
        wd_o = ~wd_o; // released bus shows no stale byte
        repeat (11) @(negedge ref_clk_i);
    end
endtask
endmodule // lhb_host

/* test/test_lhb_port.sv */
`timescale 1ns/1ps
module test_lhb_port;
reg ref_clk_i, nrst_i, direct_i, power_save_i, rd;
reg [1:0] bus_mode_i, clock_div_select_i, bpp_i;
reg [7:0] rd_data_i, total_row_bytes_i, row_bytes_i, wd;
wire cs_n, as_n, stb, dir, ack_n, window_o;
wire [7:0] data_o, hd, wr_data_o;
integer seed, err_count, checks_done, m, n, len, w;
lhb_port lhb_port_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_mode_i(bus_mode_i), .direct_i(direct_i),
    .power_save_i(power_save_i), .cs_n_i(cs_n), .addr_strobe_n_i(as_n), .rd_n_i(stb), .wr_n_i(dir), .data_i(hd),
    .data_o(data_o), .data_oe_o(), .transfer_ack_n_o(ack_n), .transfer_ack_oe_o(), .wr_stb_o(),
    .wr_data_o(wr_data_o), .rd_stb_o(), .rd_data_i(rd_data_i), .clock_div_select_i(clock_div_select_i),
    .bpp_i(bpp_i), .total_row_bytes_i(total_row_bytes_i), .row_bytes_i(row_bytes_i), .shift_clk_en_o(),
    .line_pulse_o(), .window_o(window_o));
lhb_host lhb_host_inst (.ref_clk_i(ref_clk_i), .ack_n_i(ack_n), .rdata_i(data_o), .cs_n_o(cs_n), .as_n_o(as_n),
    .stb_o(stb), .dir_o(dir), .wd_o(hd));
// 250 MHz clock
initial
begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
end
// window length: divider 4 << d, depth code d
function integer wlen(input integer d, input integer r);
    wlen = (20 - r - 3 + d) * (4 << d) * 2;
endfunction
task chk(input [15:0] got, input [15:0] want);
    begin
        checks_done = checks_done + 1;
        if (got !== want)
        begin
            err_count = err_count + 1;
            $display("Error %0t: got %h want %h", $time, got, want);
        end
    end
endtask
task summarize;
    begin
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
endtask
task rst;
    begin
        nrst_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        nrst_i = 1'b1;
    end
endtask
// window per divider and depth code, then transfers in every bus style
initial
begin
    seed = 32'h2729063f;
    {err_count, checks_done} = 64'h0;
    {direct_i, power_save_i, bus_mode_i, clock_div_select_i, bpp_i, rd} = 9'h0;
    {rd_data_i, total_row_bytes_i, row_bytes_i, wd} = {8'h0, 8'h14, 8'h0f, 8'h0};
    rst;
    for (m = 0; m < 3; m = m + 1)
    begin
        clock_div_select_i = m[1:0];
        bpp_i = m[1:0];
        row_bytes_i = 8'h0b + 8'({$random(seed)} % 5);
        rst;
        for (n = 0; n < 2000 && !window_o; n = n + 1)
            @(negedge ref_clk_i);
        for (len = 0; len < 2000 && window_o; len = len + 1)
            @(negedge ref_clk_i);
        chk(len[15:0], wlen(m, row_bytes_i));
        if (n == 2000 || len == 2000)
            summarize;
    end
    for (m = 0; m < 3; m = m + 1)
        for (n = 0; n < 8; n = n + 1)
        begin
            bus_mode_i = m[1:0];
            {direct_i, power_save_i} = 2'($random(seed));
            rd_data_i = 8'($random(seed));
            wd = 8'($random(seed));
            rd = n == 0 ? 1'b1 : n == 1 ? 1'b0 : 1'($random(seed));
            // start each access at the opening of a fresh access window
            for (w = 0; w < 400 && window_o; w = w + 1)
                @(negedge ref_clk_i);
            for (len = 0; len < 400 && !window_o; len = len + 1)
                @(negedge ref_clk_i);
            chk({w == 400, len == 400}, 16'h0000);
            if (w == 400 || len == 400)
                summarize;
            lhb_host_inst.xfer(rd, wd, m[1:0]);
            if (rd)
                chk(lhb_host_inst.got, rd_data_i);
            else
                chk(wr_data_o, wd);
            chk(lhb_host_inst.tmo, 1'b0);
            if (lhb_host_inst.tmo)
                summarize;
        end
    summarize;
end
endmodule // test_lhb_port
